// ===== logic/pcis_pkg.sv
// Shared constants for the PDM capture and I2S slave front end
package pcis_pkg;

  // System clock
  localparam longint unsigned SYS_CLK_HZ     = 64'd200_000_000;

  // Microphone clock from a fractional phase accumulator
  localparam longint unsigned PDM_CLK_HZ     = 64'd3_072_000;
  localparam int              PDM_ACC_W      = 24;
  localparam longint unsigned PDM_INC_WIDE   = ((64'd2 * PDM_CLK_HZ) << PDM_ACC_W) / SYS_CLK_HZ;
  localparam logic [PDM_ACC_W-1:0] PDM_HALF_INC = PDM_ACC_W'(PDM_INC_WIDE);

  // I2S bit clock rates and measured periods
  localparam longint unsigned BCLK_16K_HZ    = 64'd1_024_000;
  localparam longint unsigned BCLK_48K_HZ    = 64'd3_072_000;
  localparam int              PER_W          = 10;
  localparam logic [PER_W-1:0] BCLK_16K_CYC  = PER_W'(SYS_CLK_HZ / BCLK_16K_HZ);
  localparam logic [PER_W-1:0] BCLK_48K_CYC  = PER_W'(SYS_CLK_HZ / BCLK_48K_HZ);
  localparam logic [PER_W-1:0] BCLK_16K_TOL  = PER_W'(SYS_CLK_HZ / BCLK_16K_HZ / 8);
  localparam logic [PER_W-1:0] BCLK_48K_TOL  = PER_W'(SYS_CLK_HZ / BCLK_48K_HZ / 8);
  localparam logic [PER_W-1:0] BCLK_TIMEOUT  = PER_W'(2 * (SYS_CLK_HZ / BCLK_16K_HZ));

  // Frame layout
  localparam int              SLOT_BITS      = 32;
  localparam int              FRAME_BITS     = 64;
  localparam logic [5:0]      SLOT_LAST      = 6'h1f;
  localparam logic [1:0]      LR_SEEN_FULL   = 2'h2;

endpackage

// ===== logic/pcis_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pcis_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_reg;
      logic hold_reg;
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_reg <= 1'b0;
          hold_reg <= 1'b0;
        end else begin
          meta_reg <= async_i[g];
          hold_reg <= meta_reg;
        end
      end
      assign sync_o[g] = hold_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== logic/pcis_fifo.sv
// Transmit sample FIFO with registered read data and registered ready
`timescale 1ns/1ps
`default_nettype none
module pcis_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  // Drain side
  output var  logic             out_valid_o,
  output var  logic [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("pcis_fifo DEPTH must be a power of two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             ready_reg, ready_next;
  logic             ovalid_reg, ovalid_next;
  logic [WIDTH-1:0] odata_reg, odata_next;
  logic             push;
  logic             load;

  always_comb begin
    push        = in_valid_i && ready_reg;
    load        = (wr_ptr_reg != rd_ptr_reg) && (!ovalid_reg || out_ready_i);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    ovalid_next = load ? 1'b1 : (out_ready_i ? 1'b0 : ovalid_reg);
    odata_next  = load ? mem[rd_ptr_reg[AW-1:0]] : odata_reg;
    // Ready drops one entry early so a registered ready never overfills
    ready_next  = (wr_ptr_next - rd_ptr_next) < (AW+1)'(DEPTH - 1) ||
                  ((wr_ptr_next - rd_ptr_next) == (AW+1)'(DEPTH - 1) && !push);
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      ready_reg  <= 1'b0;
      ovalid_reg <= 1'b0;
      odata_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      ready_reg  <= ready_next;
      ovalid_reg <= ovalid_next;
      odata_reg  <= odata_next;
    end
  end

  assign in_ready_o  = ready_reg;
  assign out_valid_o = ovalid_reg;
  assign out_data_o  = odata_reg;

endmodule
`default_nettype wire

// ===== logic/pcis_top.sv
// PDM microphone capture and I2S slave audio port
//
// Behaviour
// - While capture is enabled a continuous 3.072 MHz microphone clock is driven out.
// - The shared PDM line is sampled on both clock edges, one microphone per edge.
// - The audio port is a slave only; one host clock set times both directions.
// - The bit clock runs at 1.024 MHz or 3.072 MHz, chosen by configuration.
// - The frame clock is the bit clock divided by 64, 32 bit clocks per channel slot.
// - Each sample's MSB starts one bit clock after the frame clock changes phase.
// - Processed audio is shifted out to the host and reference audio taken in.
// - Control commands arriving before the audio clocks run are not processed.
`timescale 1ns/1ps
`default_nettype none
module pcis_top
  import pcis_pkg::*;
#(
  parameter int SAMPLE_W   = 24,
  parameter int FIFO_DEPTH = 32,
  parameter int CMD_W      = 8
) (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // Microphone pins
  input  wire logic                  pdm_enable_i,
  input  wire logic                  pdm_shared_data_i,
  output var  logic                  pdm_bit_clock_o,
  // Captured microphone bits
  output var  logic                  pdm_left_o,
  output var  logic                  pdm_right_o,
  output var  logic                  pdm_valid_o,
  // Audio serial pins
  input  wire logic                  i2s_bclk_i,
  input  wire logic                  frame_select_clock_i,
  input  wire logic                  i2s_din_i,
  output var  logic                  i2s_dout_o,
  input  wire logic                  rate_48k_i,
  // Processed audio to send, {left, right}
  input  wire logic                  tx_valid_i,
  input  wire logic [2*SAMPLE_W-1:0] tx_data_i,
  output var  logic                  tx_ready_o,
  // Reference audio received
  output var  logic [SAMPLE_W-1:0]   rx_sample_o,
  output var  logic                  rx_right_o,
  output var  logic                  rx_valid_o,
  // Link status
  output var  logic                  i2s_active_o,
  output var  logic                  frame_err_o,
  output var  logic                  tx_underrun_o,
  // Control command gate
  input  wire logic                  ctrl_valid_i,
  input  wire logic [CMD_W-1:0]      ctrl_data_i,
  output var  logic                  ctrl_valid_o,
  output var  logic [CMD_W-1:0]      ctrl_data_o,
  output var  logic                  ctrl_drop_o
);
  import pcis_pkg::*;

  generate
    if (SAMPLE_W < 8 || SAMPLE_W > SLOT_BITS) begin : g_chk
      $error("pcis_top SAMPLE_W must lie in 8..32");
    end
  endgenerate

  // Pin synchronisers
  logic [3:0] sync_q;
  logic       s_pdm, s_bclk, s_lrck, s_din;

  pcis_sync #(.W(4)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({pdm_shared_data_i, i2s_bclk_i, frame_select_clock_i, i2s_din_i}),
    .sync_o    (sync_q)
  );
  assign {s_pdm, s_bclk, s_lrck, s_din} = sync_q;

  // Microphone clock and capture
  logic [PDM_ACC_W-1:0] acc_reg, acc_next;
  logic                 mclk_reg, mclk_next;
  logic                 left_reg, left_next;
  logic                 right_reg, right_next;
  logic                 pvalid_reg, pvalid_next;
  logic [PDM_ACC_W:0]   acc_sum;

  always_comb begin
    acc_sum     = {1'b0, acc_reg} + {1'b0, PDM_HALF_INC};
    acc_next    = acc_sum[PDM_ACC_W-1:0];
    mclk_next   = mclk_reg;
    left_next   = left_reg;
    right_next  = right_reg;
    pvalid_next = 1'b0;
    if (!pdm_enable_i) begin
      acc_next  = '0;
      mclk_next = 1'b0;
    end else if (acc_sum[PDM_ACC_W]) begin
      // Accumulator carry marks each half period; edges jitter by one cycle
      mclk_next = !mclk_reg;
      // Sampled just before the edge, the line holds the other half's talker
      if (!mclk_reg) begin
        right_next = s_pdm;
      end else begin
        left_next   = s_pdm;
        pvalid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_reg    <= '0;
      mclk_reg   <= 1'b0;
      left_reg   <= 1'b0;
      right_reg  <= 1'b0;
      pvalid_reg <= 1'b0;
    end else begin
      acc_reg    <= acc_next;
      mclk_reg   <= mclk_next;
      left_reg   <= left_next;
      right_reg  <= right_next;
      pvalid_reg <= pvalid_next;
    end
  end

  // Bit clock edges and link monitor
  logic             bclk_d_reg, bclk_d_next;
  logic             lrck_last_reg, lrck_last_next;
  logic [PER_W-1:0] per_cnt_reg, per_cnt_next;
  logic             bclk_ok_reg, bclk_ok_next;
  logic [1:0]       lr_seen_reg, lr_seen_next;
  logic [5:0]       bit_cnt_reg, bit_cnt_next;
  logic             active_reg, active_next;
  logic             ferr_reg, ferr_next;
  logic             rise, fall, lr_change;
  logic [PER_W-1:0] exp_cyc, exp_tol;

  always_comb begin
    rise           = s_bclk && !bclk_d_reg;
    fall           = !s_bclk && bclk_d_reg;
    lr_change      = rise && (s_lrck != lrck_last_reg);
    exp_cyc        = rate_48k_i ? BCLK_48K_CYC : BCLK_16K_CYC;
    exp_tol        = rate_48k_i ? BCLK_48K_TOL : BCLK_16K_TOL;
    bclk_d_next    = s_bclk;
    lrck_last_next = rise ? s_lrck : lrck_last_reg;
    per_cnt_next   = per_cnt_reg;
    bclk_ok_next   = bclk_ok_reg;
    lr_seen_next   = lr_seen_reg;
    bit_cnt_next   = bit_cnt_reg;
    ferr_next      = 1'b0;
    if (rise) begin
      per_cnt_next = PER_W'(1);
      bclk_ok_next = (per_cnt_reg + exp_tol >= exp_cyc) && (per_cnt_reg <= exp_cyc + exp_tol);
      if (lr_change) begin
        bit_cnt_next = '0;
        // A slot other than 32 bit clocks breaks the divide-by-64 frame
        if (lr_seen_reg == LR_SEEN_FULL && bit_cnt_reg != SLOT_LAST) begin
          ferr_next    = 1'b1;
          lr_seen_next = 2'h1;
        end else if (lr_seen_reg != LR_SEEN_FULL) begin
          lr_seen_next = lr_seen_reg + 2'h1;
        end
      end else if (bit_cnt_reg != 6'h3f) begin
        bit_cnt_next = bit_cnt_reg + 6'h1;
      end
    end else if (per_cnt_reg >= BCLK_TIMEOUT) begin
      // Stopped clocks take the port out of service
      bclk_ok_next = 1'b0;
      lr_seen_next = '0;
    end else begin
      per_cnt_next = per_cnt_reg + PER_W'(1);
    end
    active_next = bclk_ok_reg && (lr_seen_reg == LR_SEEN_FULL);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bclk_d_reg    <= 1'b0;
      lrck_last_reg <= 1'b0;
      per_cnt_reg   <= '0;
      bclk_ok_reg   <= 1'b0;
      lr_seen_reg   <= '0;
      bit_cnt_reg   <= '0;
      active_reg    <= 1'b0;
      ferr_reg      <= 1'b0;
    end else begin
      bclk_d_reg    <= bclk_d_next;
      lrck_last_reg <= lrck_last_next;
      per_cnt_reg   <= per_cnt_next;
      bclk_ok_reg   <= bclk_ok_next;
      lr_seen_reg   <= lr_seen_next;
      bit_cnt_reg   <= bit_cnt_next;
      active_reg    <= active_next;
      ferr_reg      <= ferr_next;
    end
  end

  // Reference audio receiver
  logic [SAMPLE_W-1:0] rx_shift_reg, rx_shift_next;
  logic [SAMPLE_W-1:0] rx_out_reg, rx_out_next;
  logic                rx_right_reg, rx_right_next;
  logic                rx_valid_reg, rx_valid_next;
  logic [5:0]          rx_idx;

  always_comb begin
    rx_idx        = bit_cnt_reg + 6'h1;
    rx_shift_next = rx_shift_reg;
    rx_out_next   = rx_out_reg;
    rx_right_next = rx_right_reg;
    rx_valid_next = 1'b0;
    if (lr_change) begin
      rx_shift_next = '0;
      if (active_reg) begin
        rx_out_next   = rx_shift_reg;
        rx_right_next = lrck_last_reg;
        rx_valid_next = 1'b1;
      end
    end else if (rise && rx_idx >= 6'h1 && rx_idx <= 6'(SAMPLE_W)) begin
      // First bit after the phase change is skipped, MSB lands next
      rx_shift_next = {rx_shift_reg[SAMPLE_W-2:0], s_din};
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_shift_reg <= '0;
      rx_out_reg   <= '0;
      rx_right_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_out_reg   <= rx_out_next;
      rx_right_reg <= rx_right_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  // Processed audio transmitter fed from the FIFO
  logic                  fifo_valid;
  logic [2*SAMPLE_W-1:0] fifo_data;
  logic                  fifo_pop;

  pcis_fifo #(.WIDTH(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (tx_valid_i),
    .in_data_i   (tx_data_i),
    .in_ready_o  (tx_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  logic [SLOT_BITS-1:0] tx_shift_reg, tx_shift_next;
  logic [SAMPLE_W-1:0]  r_hold_reg, r_hold_next;
  logic                 pend_reg, pend_next;
  logic                 slot_r_reg, slot_r_next;
  logic                 dout_reg, dout_next;
  logic                 urun_reg, urun_next;
  logic [SLOT_BITS-1:0] word;

  always_comb begin
    pend_next     = pend_reg;
    slot_r_next   = slot_r_reg;
    tx_shift_next = tx_shift_reg;
    r_hold_next   = r_hold_reg;
    dout_next     = dout_reg;
    urun_next     = 1'b0;
    fifo_pop      = 1'b0;
    word          = '0;
    if (lr_change) begin
      pend_next   = 1'b1;
      slot_r_next = s_lrck;
    end else if (fall && pend_reg) begin
      // Falling edge after the phase change puts the MSB out
      pend_next = 1'b0;
      if (slot_r_reg) begin
        word[SLOT_BITS-1 -: SAMPLE_W] = r_hold_reg;
      end else if (active_reg && fifo_valid) begin
        fifo_pop                      = 1'b1;
        word[SLOT_BITS-1 -: SAMPLE_W] = fifo_data[2*SAMPLE_W-1:SAMPLE_W];
        r_hold_next                   = fifo_data[SAMPLE_W-1:0];
      end else begin
        // Starved frames go out as silence on both channels
        r_hold_next = '0;
        urun_next   = active_reg;
      end
      dout_next     = word[SLOT_BITS-1];
      tx_shift_next = {word[SLOT_BITS-2:0], 1'b0};
    end else if (fall) begin
      dout_next     = tx_shift_reg[SLOT_BITS-1];
      tx_shift_next = {tx_shift_reg[SLOT_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift_reg <= '0;
      r_hold_reg   <= '0;
      pend_reg     <= 1'b0;
      slot_r_reg   <= 1'b0;
      dout_reg     <= 1'b0;
      urun_reg     <= 1'b0;
    end else begin
      tx_shift_reg <= tx_shift_next;
      r_hold_reg   <= r_hold_next;
      pend_reg     <= pend_next;
      slot_r_reg   <= slot_r_next;
      dout_reg     <= dout_next;
      urun_reg     <= urun_next;
    end
  end

  // Control command gate
  logic             cvalid_reg, cvalid_next;
  logic [CMD_W-1:0] cdata_reg, cdata_next;
  logic             cdrop_reg, cdrop_next;

  always_comb begin
    cvalid_next = ctrl_valid_i && active_reg;
    cdrop_next  = ctrl_valid_i && !active_reg;
    cdata_next  = cvalid_next ? ctrl_data_i : cdata_reg;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cvalid_reg <= 1'b0;
      cdata_reg  <= '0;
      cdrop_reg  <= 1'b0;
    end else begin
      cvalid_reg <= cvalid_next;
      cdata_reg  <= cdata_next;
      cdrop_reg  <= cdrop_next;
    end
  end

  assign pdm_bit_clock_o = mclk_reg;
  assign pdm_left_o      = left_reg;
  assign pdm_right_o     = right_reg;
  assign pdm_valid_o     = pvalid_reg;
  assign i2s_dout_o      = dout_reg;
  assign rx_sample_o     = rx_out_reg;
  assign rx_right_o      = rx_right_reg;
  assign rx_valid_o      = rx_valid_reg;
  assign i2s_active_o    = active_reg;
  assign frame_err_o     = ferr_reg;
  assign tx_underrun_o   = urun_reg;
  assign ctrl_valid_o    = cvalid_reg;
  assign ctrl_data_o     = cdata_reg;
  assign ctrl_drop_o     = cdrop_reg;

endmodule
`default_nettype wire

// ===== dv/pcis_host_model.sv
// Host audio clock master and microphone pair model
`timescale 1ns/1ps
`default_nettype none
module pcis_host_model #(
  parameter logic [23:0] RX_L = 24'h9abcde,
  parameter logic [23:0] RX_R = 24'h123456
) (
  // Bench control
  input  wire logic        sys_clk_i,
  input  wire logic        run_i,
  input  wire logic [7:0]  period_i,
  input  wire logic        mic_l_i,
  input  wire logic        mic_r_i,
  // Audio pins
  output var  logic        bclk_o,
  output var  logic        lrck_o,
  output var  logic        din_o,
  input  wire logic        dout_i,
  // Slot just heard on the device output
  output var  logic [31:0] slot_o,
  output var  logic        slot_r_o,
  output var  logic        slot_dn_o,
  // Microphone pins
  input  wire logic        pdm_clk_i,
  output var  logic        pdm_data_o
);
  logic [7:0]  cnt;
  logic [5:0]  n;
  logic [4:0]  p;
  logic [31:0] sh;
  logic [23:0] smp;
  initial begin
    {cnt, n, sh, bclk_o, lrck_o, din_o, slot_o, slot_r_o, slot_dn_o} = '0;
  end
  // Each mic owns one clock half, so the shared line never floats
  assign pdm_data_o = pdm_clk_i ? mic_l_i : mic_r_i;
  // One clock set times both directions; it stands still while stopped
  always @(posedge sys_clk_i) begin
    slot_dn_o <= 1'b0;
    // Bit and frame clocks divide down from the bench system clock by period_i
    cnt <= cnt + 8'h1;
    if (!run_i) begin
      cnt <= cnt;
    end else if (cnt >= (bclk_o ? period_i - (period_i >> 1) : period_i >> 1) - 8'h1) begin
      cnt <= 8'h0;
      bclk_o <= !bclk_o;
      if (!bclk_o) begin
        sh <= {sh[30:0], dout_i};
      end else begin
        n = n + 6'h1;
        p = n[4:0];
        smp = n[5] ? RX_R : RX_L;
        lrck_o <= n[5];
        din_o <= (p >= 5'h1 && p <= 5'h18) ? smp[5'h18 - p] : 1'b0;
        if (p == 5'h1) begin
          slot_o <= sh;
          slot_r_o <= !n[5];
          slot_dn_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/pcis_top_sva.sv
// Port-level assertions for the front end top
`timescale 1ns/1ps
`default_nettype none
module pcis_top_sva #(
  parameter int SAMPLE_W   = 24,
  parameter int FIFO_DEPTH = 32,
  parameter int CMD_W      = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Microphone side
  input  wire logic             pdm_enable_i,
  input  wire logic             pdm_bit_clock_o,
  input  wire logic             pdm_valid_o,
  // Audio link
  input  wire logic             i2s_bclk_i,
  input  wire logic             frame_select_clock_i,
  input  wire logic             i2s_dout_o,
  input  wire logic             rx_valid_o,
  input  wire logic             rx_right_o,
  input  wire logic             i2s_active_o,
  input  wire logic             tx_underrun_o,
  // Command gate
  input  wire logic             ctrl_valid_i,
  input  wire logic [CMD_W-1:0] ctrl_data_i,
  input  wire logic             ctrl_valid_o,
  input  wire logic [CMD_W-1:0] ctrl_data_o,
  input  wire logic             ctrl_drop_o
);
  logic       clk_q;
  logic       seen;
  logic       bclk_q;
  logic       lr_rise;
  logic [5:0] hcnt;
  // First half after enable is partial, so only later halves are measured
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {clk_q, seen, bclk_q, lr_rise, hcnt} <= '0;
    end else begin
      clk_q <= pdm_bit_clock_o;
      bclk_q <= i2s_bclk_i;
      hcnt <= (pdm_bit_clock_o != clk_q) ? 6'h1 : hcnt + 6'h1;
      seen <= pdm_enable_i && (seen || pdm_bit_clock_o != clk_q);
      if (i2s_bclk_i && !bclk_q) lr_rise <= frame_select_clock_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  clk_off_a: assert property (!pdm_enable_i [*2] |-> !pdm_bit_clock_o)
    else $error("mic clock running while disabled");
  clk_half_a: assert property (pdm_enable_i && seen && pdm_bit_clock_o != clk_q |-> hcnt inside {6'h20, 6'h21})
    else $error("mic clock half period out of range");
  mic_pulse_a: assert property (pdm_valid_o |-> !pdm_bit_clock_o ##1 !pdm_valid_o)
    else $error("mic pair pulse misplaced");
  ctrl_pass_a: assert property (ctrl_valid_i && i2s_active_o ##1 i2s_active_o |->
    ctrl_valid_o && !ctrl_drop_o && ctrl_data_o == $past(ctrl_data_i))
    else $error("command not passed while active");
  ctrl_drop_a: assert property (ctrl_valid_i && !i2s_active_o ##1 !i2s_active_o |-> ctrl_drop_o && !ctrl_valid_o)
    else $error("command not dropped while idle");
  ctrl_only_a: assert property (ctrl_valid_o || ctrl_drop_o |-> $past(ctrl_valid_i))
    else $error("command output without request");
  rx_change_a: assert property (i2s_active_o && i2s_bclk_i && !bclk_q && frame_select_clock_i != lr_rise
    |-> ##[1:8] rx_valid_o)
    else $error("no sample at frame phase change");
  dout_idle_a: assert property ($fell(i2s_bclk_i) && !i2s_active_o ##1 !i2s_active_o [*7] |-> !i2s_dout_o)
    else $error("data sent while link idle");
  dout_edge_a: assert property ($changed(i2s_dout_o) |-> !i2s_bclk_i)
    else $error("data changed while bit clock high");
  under_left_a: assert property (tx_underrun_o |-> !frame_select_clock_i)
    else $error("underrun outside left slot");
  cover property (rx_valid_o && rx_right_o);
  cover property (ctrl_valid_o);
  cover property (ctrl_drop_o);
  cover property (tx_underrun_o);
endmodule
bind pcis_top pcis_top_sva #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH), .CMD_W(CMD_W)) u_sva (
  .sys_clk_i, .reset_n_i, .pdm_enable_i, .pdm_bit_clock_o, .pdm_valid_o, .i2s_bclk_i,
  .frame_select_clock_i, .i2s_dout_o, .rx_valid_o, .rx_right_o, .i2s_active_o, .tx_underrun_o,
  .ctrl_valid_i, .ctrl_data_i, .ctrl_valid_o, .ctrl_data_o, .ctrl_drop_o);
`default_nettype wire

// ===== dv/pcis_top_test.sv
// Self-checking bench for the PDM capture and audio slave front end
`timescale 1ns/1ps
`default_nettype none
module pcis_top_test;
  import pcis_pkg::*;
  // Short buffer keeps the drain within a few frames
  localparam int DEPTH = 4;
  // Registered read port holds one word beyond the store
  localparam int HELD = DEPTH + 1;
  localparam logic [23:0] RX_L = 24'h9abcde;
  localparam logic [23:0] RX_R = 24'h123456;
  logic        clk, reset_n, pdm_en, mic_l, mic_r, pdm_line, pdm_clk, pdm_l, pdm_r, pdm_v;
  logic        bclk, lrck, din, dout, rate48, tx_v, tx_rdy, rx_r, rx_v, act, ferr, und;
  logic        c_v, c_vo, c_drop, run, slot_r, slot_dn;
  logic [7:0]  c_d, c_do, period;
  logic [47:0] tx_d;
  logic [23:0] rx_s;
  logic [31:0] slot;
  int          n_fail = 0;
  int          checked = 0;
  pcis_top #(.FIFO_DEPTH(DEPTH)) u_dut (
    .sys_clk_i(clk), .reset_n_i(reset_n), .pdm_enable_i(pdm_en), .pdm_shared_data_i(pdm_line),
    .pdm_bit_clock_o(pdm_clk), .pdm_left_o(pdm_l), .pdm_right_o(pdm_r), .pdm_valid_o(pdm_v),
    .i2s_bclk_i(bclk), .frame_select_clock_i(lrck), .i2s_din_i(din), .i2s_dout_o(dout),
    .rate_48k_i(rate48), .tx_valid_i(tx_v), .tx_data_i(tx_d), .tx_ready_o(tx_rdy),
    .rx_sample_o(rx_s), .rx_right_o(rx_r), .rx_valid_o(rx_v), .i2s_active_o(act),
    .frame_err_o(ferr), .tx_underrun_o(und), .ctrl_valid_i(c_v), .ctrl_data_i(c_d),
    .ctrl_valid_o(c_vo), .ctrl_data_o(c_do), .ctrl_drop_o(c_drop));
  pcis_host_model #(.RX_L(RX_L), .RX_R(RX_R)) u_host (
    .sys_clk_i(clk), .run_i(run), .period_i(period), .mic_l_i(mic_l), .mic_r_i(mic_r),
    .bclk_o(bclk), .lrck_o(lrck), .din_o(din), .dout_i(dout), .slot_o(slot),
    .slot_r_o(slot_r), .slot_dn_o(slot_dn), .pdm_clk_i(pdm_clk), .pdm_data_o(pdm_line));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [47:0] word(input int k);
    return {24'h810000 | 24'(k), 24'h420000 | 24'(k)};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_act(input logic lvl, input int lim);
    int n;
    n = 0;
    while (act !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        check(act, lvl);
        close_out();
      end
    end
  endtask
  task automatic t_ctrl(input logic pass);
    @(negedge clk);
    c_v = 1'b1;
    c_d = pass ? 8'h5a : 8'ha5;
    @(negedge clk);
    c_v = 1'b0;
    // Gate answers stand for one cycle only
    check({c_vo, c_drop}, {pass, !pass});
    if (pass) check(c_do, c_d);
    @(negedge clk);
    check({c_vo, c_drop}, 2'b00);
  endtask
  task automatic t_mic();
    int n;
    n = 0;
    {pdm_en, mic_l, mic_r} = 3'b110;
    repeat (200) @(negedge clk);
    repeat (6510) begin
      @(negedge clk);
      if (pdm_v === 1'b1) n++;
    end
    check(48'(n > 98 && n < 101), 48'h1);
    check({pdm_l, pdm_r}, 2'b10);
    {mic_l, mic_r} = 2'b01;
    repeat (200) @(negedge clk);
    check({pdm_l, pdm_r}, 2'b01);
    pdm_en = 1'b0;
    repeat (4) @(negedge clk);
    check(pdm_clk, 1'b0);
  endtask
  task automatic t_rate16();
    {period, rate48, run} = {8'd195, 2'b01};
    wait_act(1'b1, 60000);
    t_ctrl(1'b1);
    rate48 = 1'b1;
    wait_act(1'b0, 3000);
    run = 1'b0;
    t_ctrl(1'b0);
  endtask
  task automatic t_fill();
    int k;
    k = 0;
    repeat (12) begin
      @(negedge clk);
      tx_v = 1'b1;
      tx_d = word(k);
      if (tx_rdy === 1'b1) k++;
    end
    @(negedge clk);
    tx_v = 1'b0;
    check(48'(k), 48'(HELD));
  endtask
  task automatic t_link();
    logic [47:0] w;
    int i, nr, nf, nu;
    {i, nr, nf, nu} = '0;
    {period, run} = {8'd65, 1'b1};
    wait_act(1'b1, 40000);
    repeat (40000) begin
      @(negedge clk);
      if (ferr === 1'b1) nf++;
      if (rx_v === 1'b1) nr++;
      if (rx_v === 1'b1) check(rx_s, rx_r ? RX_R : RX_L);
      if (slot_dn === 1'b1 && (i > 0 || (slot != 32'h0 && !slot_r))) begin
        w = word(i / 2);
        check({slot_r, slot}, {i[0], i[0] ? w[23:0] : w[47:24], 8'h00});
        i++;
      end
      if (i == 2 * HELD) break;
    end
    repeat (9000) begin
      @(negedge clk);
      if (und === 1'b1) nu++;
    end
    check(48'(i), 48'(2 * HELD));
    check(48'(nr > 4 && nu > 0), 48'h1);
    check(48'(nf), 48'h0);
  endtask
  initial begin
    {reset_n, pdm_en, mic_l, mic_r, rate48, tx_v, c_v, run} = '0;
    {tx_d, c_d, period} = '0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    t_ctrl(1'b0);
    t_mic();
    t_rate16();
    t_fill();
    t_link();
    close_out();
  end
endmodule
`default_nettype wire
